// *** inc/acrc_pkg.sv ***
// Constants, codes and helpers for the audio clock-domain and rate control block.
// Assumes a single 25 MHz core clock and a plain register port with byte offsets.
package acrc_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [15:0] MAIN_CLK_CFG_OFF = 16'h1404;
  localparam logic [15:0] MAIN_CLK_STS_OFF = 16'h1408;
  localparam logic [15:0] SEC_CLK_CFG_OFF = 16'h1410;
  localparam logic [15:0] SEC_CLK_STS_OFF = 16'h1414;
  localparam logic [15:0] MAIN_RATE_OFF = 16'h1420;
  localparam logic [15:0] MAIN_RATE_STS_OFF = 16'h1440;
  localparam logic [15:0] SEC_RATE_OFF = 16'h1460;
  localparam logic [15:0] SEC_RATE_STS_OFF = 16'h1470;
  localparam logic [15:0] PATH_REQ_OFF = 16'h1480;
  localparam logic [15:0] PATH_STS_OFF = 16'h1484;
  localparam logic [15:0] EVENT_OFF = 16'h1488;
  localparam logic [15:0] REG_STRIDE = 16'h0004;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int FAM_BIT = 15;
  localparam int FREQ_LSB = 8;
  localparam int EN_BIT = 6;
  localparam int SRC_LSB = 0;
  localparam int PATH_DOM_LSB = 8;
  localparam int PATH_REQ_LSB = 16;
  localparam int MISMATCH_BIT = 8;
  localparam int NUM_MAIN_RATES = 4;
  localparam int NUM_SEC_RATES = 2;
  localparam int NUM_PATHS = 8;

  // ----------------------------------------
  // Reset values and codes
  // ----------------------------------------
  localparam logic [2:0] FREQ_RST = 3'h4;
  localparam logic [2:0] FREQ_MAX = 3'h4;
  localparam logic [4:0] SRC_RST = 5'h04;
  localparam logic [4:0] RATE_RST = 5'h03;
  localparam logic [4:0] RATE_NONE = 5'h00;
  localparam logic [4:0] SRC_IN1 = 5'h00;
  localparam logic [4:0] SRC_IN2 = 5'h01;
  localparam logic [4:0] SRC_LOOP1_X2 = 5'h04;
  localparam logic [4:0] SRC_LOOP2_X2 = 5'h05;
  localparam logic [4:0] SRC_PORT1 = 5'h08;
  localparam logic [4:0] SRC_PORT2 = 5'h09;
  localparam logic [4:0] SRC_LOOP1_X1 = 5'h0c;
  localparam logic [4:0] SRC_LOOP2_X1 = 5'h0d;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int RATE_SETTLE_NS = 1000;
  localparam int RATE_SETTLE_CYC = (RATE_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic {rs_idle, rs_wait} acrc_rate_st_e;

  // 0x01-0x05 and 0x11-0x13 are the 48k family, 0x09-0x0d the 44.1k family
  function automatic logic acrc_rate_valid(input logic [4:0] code);
    acrc_rate_valid = (code == RATE_NONE) || (code >= 5'h01 && code <= 5'h05) ||
                      (code >= 5'h09 && code <= 5'h0d) || (code >= 5'h11 && code <= 5'h13);
  endfunction

  function automatic logic acrc_rate_family(input logic [4:0] code);
    acrc_rate_family = (code >= 5'h09 && code <= 5'h0d);
  endfunction

  function automatic logic acrc_src_valid(input logic [4:0] code);
    acrc_src_valid = (code == SRC_IN1) || (code == SRC_IN2) || (code == SRC_LOOP1_X2) ||
                     (code == SRC_LOOP2_X2) || (code == SRC_PORT1) || (code == SRC_PORT2) ||
                     (code == SRC_LOOP1_X1) || (code == SRC_LOOP2_X1);
  endfunction

endpackage

// *** src/acrc_clock_rate_ctrl.sv ***
// Main and secondary audio clock selection, sample-rate selection and path-enable check.
// Assumes the register master runs on core_clk and never strobes read and write together.
//
// Notes on behaviour
// R1: Four main-domain rate selections, all of one family matching the main clock.
// R2: Two secondary-domain rate selections, related to each other and secondary clock.
// R3: Software puts two unsynchronised same-rate interfaces in different domains.
// R4: Rate writes apply after a settle delay, then show in read-only status.
// R5: Software keeps converter and microphone inputs on the main domain.
// R6: Software limits input rates when microphone bit clock is 384 or 768 kHz.
// R7: Asynchronous converter only 8 to 192 kHz, ratio at most six.
// R8: Low-power up converter takes 16/24/32/44.1 kHz and outputs 48 kHz.
// R9: Low-power down converter takes 48 kHz and outputs 16/24/32/44.1 kHz.
// R10: Synchronous converters 8 to 192 kHz, ratio 1.5 or integer 1 to 24.
// R11: External clock references lie within one percent of declared frequency.
// R12: Software enables main and secondary clocks before any audio path.
// R13: Main clock code 000 to 100 doubles per step; family bit picks 48k/44.1k.
// R14: Rate codes decode to 48k group and 44.1k group; one family throughout.
// R15: Secondary clock code uses same encoding, matched to secondary family.
// R16: Loop source offers twice loop frequency or loop frequency itself.
// R17: Software enables the source before clock enable and clears it before removal.
// R18: Family, frequency and source apply together from one write; status reports them (secondary status reports no family bit).
// R19: Frequency-only change: software clears clock enable first.
// R20: Path enable refused when domain clock is too slow; active paths untouched.
// R21: Too-slow clock raises an event line toward the interrupt controller.
// R22: Software keeps secondary clock disabled when everything is main-synchronous.
// R23: Main family bit reads 0 for 6.144 MHz multiples, 1 for 5.6448 MHz.
// R24: Too-slow events latch per domain until software clears them.
`timescale 1ns/1ns
module acrc_clock_rate_ctrl
  import acrc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [15:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rd_data,
  output logic main_clk_on,
  output logic main_clk_family_cur,
  output logic [2:0] main_clk_rate_cur,
  output logic [4:0] main_clk_src_cur,
  output logic main_fll_double,
  output logic sec_clk_on,
  output logic [2:0] sec_clk_rate_cur,
  output logic [4:0] sec_clk_src_cur,
  output logic sec_fll_double,
  output logic [NUM_PATHS-1:0] path_active,
  output logic slow_evt_main,
  output logic slow_evt_sec
);

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic main_cfg_fam;
  logic [2:0] main_cfg_freq;
  logic main_cfg_en;
  logic [4:0] main_cfg_src;
  logic sec_cfg_fam;
  logic [2:0] sec_cfg_freq;
  logic sec_cfg_en;
  logic [4:0] sec_cfg_src;
  logic [4:0] main_rate_sel [NUM_MAIN_RATES];
  logic [4:0] main_rate_applied [NUM_MAIN_RATES];
  logic [4:0] sec_rate_sel [NUM_SEC_RATES];
  logic [4:0] sec_rate_applied [NUM_SEC_RATES];
  logic [NUM_PATHS-1:0] path_dom;
  acrc_rate_st_e rate_st;
  logic [7:0] settle_cnt;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  wire wr_main_cfg = wr_en && addr == MAIN_CLK_CFG_OFF;
  wire wr_sec_cfg = wr_en && addr == SEC_CLK_CFG_OFF;
  wire wr_path = wr_en && addr == PATH_REQ_OFF;
  wire wr_evt = wr_en && addr == EVENT_OFF;
  wire [4:0] wr_src = wr_data[SRC_LSB +: 5];
  wire [2:0] wr_freq = wr_data[FREQ_LSB +: 3];
  // Reserved frequency or source codes drop the whole write so nothing half-applies
  wire wr_clk_ok = wr_freq <= FREQ_MAX && acrc_src_valid(wr_src);
  wire [4:0] wr_rate = wr_data[4:0];
  wire wr_rate_ok = acrc_rate_valid(wr_rate);
  wire [NUM_MAIN_RATES-1:0] wr_main_rate;
  wire [NUM_MAIN_RATES-1:0] main_rate_pend;
  wire [NUM_SEC_RATES-1:0] wr_sec_rate;
  wire [NUM_SEC_RATES-1:0] sec_rate_pend;
  wire rate_write = |wr_main_rate || |wr_sec_rate;
  wire settle_done = rate_st == rs_wait && settle_cnt == 8'h00;

  // ----------------------------------------
  // Rate selections
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NUM_MAIN_RATES; gi++) begin : g_main_rate
      assign wr_main_rate[gi] = wr_en && wr_rate_ok &&
                                addr == MAIN_RATE_OFF + 16'(gi) * REG_STRIDE; // see R1
      assign main_rate_pend[gi] = main_rate_sel[gi] != main_rate_applied[gi];
      always_ff @(posedge core_clk) begin
        if (rst) begin
          main_rate_sel[gi] <= RATE_RST;
          main_rate_applied[gi] <= RATE_NONE;
        end else begin
          if (wr_main_rate[gi]) begin
            main_rate_sel[gi] <= wr_rate; // see R14
          end
          if (settle_done) begin
            main_rate_applied[gi] <= main_rate_sel[gi]; // see R4
          end
        end
      end
    end
    for (gi = 0; gi < NUM_SEC_RATES; gi++) begin : g_sec_rate
      assign wr_sec_rate[gi] = wr_en && wr_rate_ok &&
                               addr == SEC_RATE_OFF + 16'(gi) * REG_STRIDE; // see R2
      assign sec_rate_pend[gi] = sec_rate_sel[gi] != sec_rate_applied[gi];
      always_ff @(posedge core_clk) begin
        if (rst) begin
          sec_rate_sel[gi] <= RATE_RST;
          sec_rate_applied[gi] <= RATE_NONE;
        end else begin
          if (wr_sec_rate[gi]) begin
            sec_rate_sel[gi] <= wr_rate;
          end
          if (settle_done) begin
            sec_rate_applied[gi] <= sec_rate_sel[gi]; // see R4
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Deferred rate application
  // ----------------------------------------
  // A write during the wait restarts it, so a burst of writes lands together
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rate_st <= rs_wait;
      settle_cnt <= 8'(RATE_SETTLE_CYC - 1);
    end else begin
      case (rate_st)
        rs_idle: begin
          if (rate_write) begin
            rate_st <= rs_wait; // see R4
            settle_cnt <= 8'(RATE_SETTLE_CYC - 1);
          end
        end
        rs_wait: begin
          if (rate_write) begin
            settle_cnt <= 8'(RATE_SETTLE_CYC - 1);
          end else if (settle_cnt == 8'h00) begin
            rate_st <= rs_idle;
          end else begin
            settle_cnt <= settle_cnt - 8'h01;
          end
        end
        default: rate_st <= rs_idle;
      endcase
    end
  end

  // ----------------------------------------
  // Clock configuration and current status
  // ----------------------------------------
  // Status follows only while the domain is enabled, i.e. reflects the running clock
  always_ff @(posedge core_clk) begin
    if (rst) begin
      main_cfg_fam <= 1'b0;
      main_cfg_freq <= FREQ_RST;
      main_cfg_en <= 1'b0;
      main_cfg_src <= SRC_RST;
      sec_cfg_fam <= 1'b0;
      sec_cfg_freq <= FREQ_RST;
      sec_cfg_en <= 1'b0;
      sec_cfg_src <= SRC_RST;
    end else begin
      if (wr_main_cfg && wr_clk_ok) begin
        main_cfg_fam <= wr_data[FAM_BIT]; // see R18
        main_cfg_freq <= wr_freq; // see R13
        main_cfg_en <= wr_data[EN_BIT];
        main_cfg_src <= wr_src;
      end
      if (wr_sec_cfg && wr_clk_ok) begin
        sec_cfg_fam <= wr_data[FAM_BIT];
        sec_cfg_freq <= wr_freq; // see R15
        sec_cfg_en <= wr_data[EN_BIT];
        sec_cfg_src <= wr_src;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      main_clk_on <= 1'b0;
      main_clk_family_cur <= 1'b0;
      main_clk_rate_cur <= 3'h0;
      main_clk_src_cur <= 5'h00;
      main_fll_double <= 1'b0;
      sec_clk_on <= 1'b0;
      sec_clk_rate_cur <= 3'h0;
      sec_clk_src_cur <= 5'h00;
      sec_fll_double <= 1'b0;
    end else begin
      main_clk_on <= main_cfg_en;
      sec_clk_on <= sec_cfg_en;
      if (main_cfg_en) begin
        main_clk_family_cur <= main_cfg_fam; // see R23
        main_clk_rate_cur <= main_cfg_freq; // see R18
        main_clk_src_cur <= main_cfg_src;
        main_fll_double <= main_cfg_src == SRC_LOOP1_X2 || main_cfg_src == SRC_LOOP2_X2; // see R16
      end
      if (sec_cfg_en) begin
        sec_clk_rate_cur <= sec_cfg_freq; // see R15
        sec_clk_src_cur <= sec_cfg_src;
        sec_fll_double <= sec_cfg_src == SRC_LOOP1_X2 || sec_cfg_src == SRC_LOOP2_X2; // see R16
      end
    end
  end

  // ----------------------------------------
  // Family consistency flags
  // ----------------------------------------
  wire main_mismatch = acrc_rate_family(main_rate_applied[0]) != main_clk_family_cur ||
                       acrc_rate_family(main_rate_applied[1]) != main_clk_family_cur ||
                       acrc_rate_family(main_rate_applied[2]) != main_clk_family_cur ||
                       acrc_rate_family(main_rate_applied[3]) != main_clk_family_cur; // see R1
  wire sec_mismatch = acrc_rate_family(sec_rate_applied[0]) != sec_cfg_fam ||
                      acrc_rate_family(sec_rate_applied[1]) != sec_cfg_fam; // see R2

  // ----------------------------------------
  // Path enable check
  // ----------------------------------------
  // Uses the clock actually running, so a pending config change cannot sneak a path in
  wire [NUM_PATHS-1:0] want = wr_data[NUM_PATHS-1:0];
  wire [NUM_PATHS-1:0] want_dom = wr_data[PATH_DOM_LSB +: NUM_PATHS];
  wire [2:0] need_freq = wr_data[PATH_REQ_LSB +: 3];
  wire main_fast = main_clk_on && main_clk_rate_cur >= need_freq;
  wire sec_fast = sec_clk_on && sec_clk_rate_cur >= need_freq;
  wire [NUM_PATHS-1:0] newly = want & ~path_active;
  wire [NUM_PATHS-1:0] accept = newly & ~want_dom & {NUM_PATHS{main_fast}} |
                                newly & want_dom & {NUM_PATHS{sec_fast}};
  wire refuse_main = wr_path && |(newly & ~want_dom) && !main_fast;
  wire refuse_sec = wr_path && |(newly & want_dom) && !sec_fast;
  wire [NUM_PATHS-1:0] next_path_active = want & (path_active | accept);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      path_active <= '0;
      path_dom <= '0;
    end else if (wr_path) begin
      path_active <= next_path_active; // see R20
      path_dom <= (path_dom & ~accept) | (want_dom & accept);
    end
  end

  // ----------------------------------------
  // Too-slow events
  // ----------------------------------------
  // Set beats write-one-clear in the same cycle so no refusal goes unseen
  always_ff @(posedge core_clk) begin
    if (rst) begin
      slow_evt_main <= 1'b0;
      slow_evt_sec <= 1'b0;
    end else begin
      slow_evt_main <= refuse_main | (slow_evt_main & ~(wr_evt & wr_data[0])); // see R21 see R24
      slow_evt_sec <= refuse_sec | (slow_evt_sec & ~(wr_evt & wr_data[1])); // see R21 see R24
    end
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (addr)
      MAIN_CLK_CFG_OFF: begin
        rd_mux[FAM_BIT] = main_cfg_fam;
        rd_mux[FREQ_LSB +: 3] = main_cfg_freq;
        rd_mux[EN_BIT] = main_cfg_en;
        rd_mux[SRC_LSB +: 5] = main_cfg_src;
      end
      MAIN_CLK_STS_OFF: begin
        rd_mux[FAM_BIT] = main_clk_family_cur; // see R23
        rd_mux[FREQ_LSB +: 3] = main_clk_rate_cur;
        rd_mux[SRC_LSB +: 5] = main_clk_src_cur;
      end
      SEC_CLK_CFG_OFF: begin
        rd_mux[FAM_BIT] = sec_cfg_fam;
        rd_mux[FREQ_LSB +: 3] = sec_cfg_freq;
        rd_mux[EN_BIT] = sec_cfg_en;
        rd_mux[SRC_LSB +: 5] = sec_cfg_src;
      end
      SEC_CLK_STS_OFF: begin
        rd_mux[FREQ_LSB +: 3] = sec_clk_rate_cur;
        rd_mux[SRC_LSB +: 5] = sec_clk_src_cur;
      end
      MAIN_RATE_OFF: rd_mux[4:0] = main_rate_sel[0];
      MAIN_RATE_OFF + REG_STRIDE: rd_mux[4:0] = main_rate_sel[1];
      MAIN_RATE_OFF + 16'h0008: rd_mux[4:0] = main_rate_sel[2];
      MAIN_RATE_OFF + 16'h000c: rd_mux[4:0] = main_rate_sel[3];
      MAIN_RATE_STS_OFF: begin
        rd_mux[4:0] = main_rate_applied[0];
        rd_mux[MISMATCH_BIT] = main_mismatch;
      end
      MAIN_RATE_STS_OFF + REG_STRIDE: rd_mux[4:0] = main_rate_applied[1];
      MAIN_RATE_STS_OFF + 16'h0008: rd_mux[4:0] = main_rate_applied[2];
      MAIN_RATE_STS_OFF + 16'h000c: rd_mux[4:0] = main_rate_applied[3];
      SEC_RATE_OFF: rd_mux[4:0] = sec_rate_sel[0];
      SEC_RATE_OFF + REG_STRIDE: rd_mux[4:0] = sec_rate_sel[1];
      SEC_RATE_STS_OFF: begin
        rd_mux[4:0] = sec_rate_applied[0];
        rd_mux[MISMATCH_BIT] = sec_mismatch;
      end
      SEC_RATE_STS_OFF + REG_STRIDE: rd_mux[4:0] = sec_rate_applied[1];
      PATH_STS_OFF: begin
        rd_mux[NUM_PATHS-1:0] = path_active;
        rd_mux[PATH_DOM_LSB +: NUM_PATHS] = path_dom;
      end
      EVENT_OFF: rd_mux[1:0] = {slow_evt_sec, slow_evt_main};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rd_data <= 32'h0000_0000;
    end else begin
      rd_data <= rd_en ? rd_mux : 32'h0000_0000;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  rate_hold_a: assert property ((rate_st == rs_wait && settle_cnt != 8'h00 && !rate_write) |=> // see R4
    $stable(main_rate_applied[0]) && $stable(sec_rate_applied[0])) else $error("rate applied early");
  rate_apply_a: assert property (wr_main_rate[0] ##1 !rate_write [*8] ##1 !rate_write [*8] ##1 // see R4
    !rate_write [*8] ##1 !rate_write |=>
    main_rate_applied[0] == main_rate_sel[0]) else $error("rate not applied in time");
  clk_atomic_a: assert property (wr_main_cfg && wr_clk_ok && wr_data[EN_BIT] |=> ##1 // see R18
    main_clk_src_cur == $past(wr_data[4:0], 2) && main_clk_rate_cur == $past(wr_data[10:8], 2) &&
    main_clk_family_cur == $past(wr_data[FAM_BIT], 2)) else $error("clock config not applied whole");
  freq_range_a: assert property (main_clk_rate_cur <= FREQ_MAX && sec_clk_rate_cur <= FREQ_MAX) // see R13
    else $error("reserved clock code running");
  family_read_a: assert property (rd_en && addr == MAIN_CLK_STS_OFF |=> // see R23
    rd_data[FAM_BIT] == $past(main_clk_family_cur)) else $error("family bit misread");
  rate_code_a: assert property (acrc_rate_valid(main_rate_applied[1]) && // see R14
    acrc_rate_valid(sec_rate_applied[1])) else $error("reserved rate applied");
  loop_double_a: assert property (main_clk_on && $past(main_cfg_en) && // see R16
    (main_clk_src_cur == SRC_LOOP1_X2 || main_clk_src_cur == SRC_LOOP2_X2) |-> main_fll_double)
    else $error("loop doubling not reported");
  keep_active_a: assert property (wr_path && (want & path_active) == path_active |=> // see R20
    (path_active & $past(path_active)) == $past(path_active)) else $error("active path dropped");
  refuse_slow_a: assert property (wr_path && !main_fast && |(newly & ~want_dom) |=> // see R20
    (path_active & ~path_dom & ~$past(path_active)) == '0 && slow_evt_main)
    else $error("slow-clock enable accepted");
  evt_sticky_a: assert property (slow_evt_sec && !(wr_evt && wr_data[1]) |=> slow_evt_sec) // see R24
    else $error("event lost without clear");

endmodule

// *** sim/acrc_host_model.sv ***
// Host model: the register master that configuration software would be.
// Assumes it shares core_clk with the block and is the only master on the port.
`timescale 1ns/1ns
module acrc_host_model
  import acrc_pkg::*;
(
  input wire logic core_clk,
  output logic [15:0] addr,
  output logic [31:0] wr_data,
  output logic wr_en,
  output logic rd_en,
  input wire logic [31:0] rd_data
);
  // ----------------------------------------
  // Bus cycles
  // ----------------------------------------
  initial begin
    addr = 16'h0000;
    wr_data = 32'h0;
    wr_en = 1'b0;
    rd_en = 1'b0;
  end

  // Idle address and data inverted, so a stale value never passes
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge core_clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge core_clk);
    wr_en <= 1'b0;
    addr <= ~a;
    wr_data <= ~d;
  endtask

  task automatic rd(input logic [15:0] a, output logic [31:0] d);
    @(posedge core_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge core_clk);
    rd_en <= 1'b0;
    addr <= ~a;
    @(posedge core_clk);
    d = rd_data;
  endtask
endmodule

// *** sim/tb_top.sv ***
// Self-checking bench for the clock-domain and rate control block.
// Assumes the host model is the only register master; core_clk at 25 MHz.
`timescale 1ns/1ns
module tb_top
  import acrc_pkg::*;
;
  logic core_clk;
  logic rst;
  logic [15:0] addr;
  logic [31:0] wr_data;
  logic wr_en;
  logic rd_en;
  logic [31:0] rd_data;
  logic main_clk_on, main_clk_family_cur, main_fll_double, sec_clk_on, sec_fll_double;
  logic [2:0] main_clk_rate_cur, sec_clk_rate_cur;
  logic [4:0] main_clk_src_cur, sec_clk_src_cur;
  logic [NUM_PATHS-1:0] path_active;
  logic slow_evt_main, slow_evt_sec;
  int error_cnt = 0;
  int n_compared = 0;
  logic [31:0] rv;
  logic [4:0] codes [13] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h09, 5'h0a, 5'h0b, 5'h0c,
                             5'h0d, 5'h11, 5'h12, 5'h13};

  acrc_clock_rate_ctrl u_acrc_clock_rate_ctrl (
    .core_clk(core_clk), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data), .main_clk_on(main_clk_on),
    .main_clk_family_cur(main_clk_family_cur), .main_clk_rate_cur(main_clk_rate_cur),
    .main_clk_src_cur(main_clk_src_cur), .main_fll_double(main_fll_double),
    .sec_clk_on(sec_clk_on), .sec_clk_rate_cur(sec_clk_rate_cur), .sec_clk_src_cur(sec_clk_src_cur),
    .sec_fll_double(sec_fll_double), .path_active(path_active), .slow_evt_main(slow_evt_main),
    .slow_evt_sec(slow_evt_sec)
  );

  acrc_host_model u_acrc_host_model (
    .core_clk(core_clk), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
    .rd_data(rd_data)
  );

  // ----------------------------------------
  // Clock, watchdog and helpers
  // ----------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    error_cnt++;
    end_sim;
  end

  task automatic end_sim;
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic w(input logic [15:0] a, input logic [31:0] d);
    u_acrc_host_model.wr(a, d);
  endtask

  task automatic rchk(input logic [15:0] a, input logic [31:0] exp);
    u_acrc_host_model.rd(a, rv);
    chk(rv, exp);
  endtask

  // Let the edge's updates land before looking
  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  function automatic logic [31:0] mst();
    mst = 32'({main_clk_on, main_clk_family_cur, main_clk_rate_cur, main_clk_src_cur, main_fll_double});
  endfunction

  function automatic logic [31:0] sst();
    sst = 32'({sec_clk_on, sec_clk_rate_cur, sec_clk_src_cur, sec_fll_double});
  endfunction

  function automatic logic [31:0] ev();
    ev = 32'({path_active, slow_evt_main, slow_evt_sec});
  endfunction

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    wt(0);
    chk(mst(), 32'h0);
    rchk(MAIN_RATE_STS_OFF, 32'h0);
    rchk(MAIN_CLK_CFG_OFF, 32'h0404);
    rchk(SEC_CLK_CFG_OFF, 32'h0404);
    rchk(16'h1500, 32'h0);
    // Path asked for with no clock: refusal expected
    w(PATH_REQ_OFF, 32'h1);
    wt(0);
    chk(ev(), 32'({8'h00, 1'b1, 1'b0}));
    w(EVENT_OFF, 32'h1);
    wt(0);
    chk(ev(), 32'h0);
    wt(30);
    for (int i = 0; i < NUM_MAIN_RATES; i++) begin
      rchk(MAIN_RATE_STS_OFF + REG_STRIDE * 16'(i), 32'h3);
    end
    // Source taken as running before enable
    w(MAIN_CLK_CFG_OFF, 32'h0444);
    wt(1);
    chk(mst(), 32'({1'b1, 1'b0, 3'h4, 5'h04, 1'b1}));
    rchk(MAIN_CLK_STS_OFF, 32'h0404);
    w(MAIN_CLK_CFG_OFF, 32'h834c);
    wt(1);
    chk(mst(), 32'({1'b1, 1'b1, 3'h3, 5'h0c, 1'b0}));
    w(MAIN_CLK_CFG_OFF, 32'h0544);
    w(MAIN_CLK_CFG_OFF, 32'h8342);
    wt(1);
    chk(mst(), 32'({1'b1, 1'b1, 3'h3, 5'h0c, 1'b0}));
    foreach (codes[i]) begin
      w(MAIN_RATE_OFF, 32'(codes[i]));
      rchk(MAIN_RATE_OFF, 32'(codes[i]));
    end
    w(MAIN_RATE_OFF, 32'h07);
    rchk(MAIN_RATE_OFF, 32'h13);
    // Rates apply only after the settle delay; a 48k rate under the 44.1k main clock flags mismatch
    w(MAIN_RATE_OFF + REG_STRIDE, 32'h0b);
    w(MAIN_RATE_OFF, 32'h03);
    rchk(MAIN_RATE_STS_OFF + REG_STRIDE, 32'h03);
    wt(30);
    rchk(MAIN_RATE_STS_OFF, 32'h0103);
    rchk(MAIN_RATE_STS_OFF + REG_STRIDE, 32'h0b);
    // Main-domain path accepted at code 3; a second needing code 4 refused, the first kept
    w(PATH_REQ_OFF, 32'h0003_0001);
    wt(0);
    chk(ev(), 32'({8'h01, 1'b0, 1'b0}));
    w(PATH_REQ_OFF, 32'h0004_0003);
    wt(0);
    chk(ev(), 32'({8'h01, 1'b1, 1'b0}));
    w(SEC_CLK_CFG_OFF, 32'h0241);
    wt(1);
    chk(sst(), 32'({1'b1, 3'h2, 5'h01, 1'b0}));
    w(SEC_RATE_OFF, 32'h12);
    w(SEC_RATE_OFF + REG_STRIDE, 32'h13);
    wt(30);
    rchk(SEC_RATE_STS_OFF, 32'h12);
    rchk(SEC_RATE_STS_OFF + REG_STRIDE, 32'h13);
    // Secondary-domain path refused while the secondary clock code 2 is too slow
    w(PATH_REQ_OFF, 32'h0003_0405);
    wt(0);
    chk(ev(), 32'({8'h01, 1'b1, 1'b1}));
    rchk(EVENT_OFF, 32'h3);
    w(EVENT_OFF, 32'h3);
    // Enable dropped before a frequency-only change
    w(SEC_CLK_CFG_OFF, 32'h0201);
    wt(1);
    chk(sst(), 32'({1'b0, 3'h2, 5'h01, 1'b0}));
    w(SEC_CLK_CFG_OFF, 32'h0341);
    wt(1);
    chk(sst(), 32'({1'b1, 3'h3, 5'h01, 1'b0}));
    w(PATH_REQ_OFF, 32'h0003_0405);
    wt(0);
    chk(ev(), 32'({8'h05, 1'b0, 1'b0}));
    rchk(PATH_STS_OFF, 32'h0405);
    w(PATH_REQ_OFF, 32'h0000_0404);
    wt(0);
    chk(ev(), 32'({8'h04, 1'b0, 1'b0}));
    // Secondary moved onto a doubled loop in one write while running
    w(SEC_CLK_CFG_OFF, 32'h0345);
    wt(1);
    chk(sst(), 32'({1'b1, 3'h3, 5'h05, 1'b1}));
    rchk(SEC_CLK_STS_OFF, 32'h0305);
    end_sim;
  end
endmodule
